/* File: fault_monitor.sv */
// Flash/torch LED driver fault supervisor with serial register link
`timescale 1ns/10ps
`include "fault_defs.svh"
module fault_monitor
   import fault_pkg::*;
#(
   parameter int unsigned WINDOW_CYCLES = `T_WINDOW_US * `CLK_MHZ,
   parameter int unsigned STEP_CYCLES   = `T_STEP_US * `CLK_MHZ,
   parameter int unsigned SHORT_CYCLES  = `T_SHORT_US * `CLK_MHZ
) (
   input  wire logic       CLOCK,
   input  wire logic       RST_N,
   input  wire logic       LINK_CLK,
   input  wire logic       SCL,
   input  wire logic       SDA_I,
   output logic            SDA_O,
   output logic            SDA_OE,
   input  wire logic       INTERFACE_SELECT,
   input  wire logic       MODE_PIN_HI,
   input  wire logic       MODE_PIN_LO,
   input  wire logic       FLASH_TRIGGER_PIN,
   input  wire logic       ENABLE,
   input  wire logic       UVLO,
   input  wire logic       OVERVOLT,
   input  wire logic       OVERHEAT,
   input  wire logic       CATHODE_LOW,
   output logic            INT_O,
   output logic            INT_OE,
   output logic            DRIVER_EN,
   output logic            FLASH_ON,
   output logic            TORCH_ON,
   output logic            INDICATOR_ON,
   output logic [4:0]      LED_CODE
);

   // ---------------- Link domain: serial register slave ----------------
   logic [1:0]  lk_pins;
   logic        scl_p_q;
   logic        sda_p_q;
   link_state_t lst_q;
   logic [3:0]  bit_cnt_q;
   logic [7:0]  sh_q;
   logic [1:0]  ptr_q;
   logic        rd_dir_q;
   logic        req_tgl_q;
   reg_req_t    req_q;
   logic        sda_oe_q;
   logic [7:0]  rd_data_q;

   // Bus pins into the link domain
   pin_sync #(.W(2)) u_link_sync (
      .clk   (LINK_CLK),
      .rst_n (RST_N),
      .d     ({SCL, SDA_I}),
      .q     (lk_pins)
   );

   wire scl_f     = lk_pins[1];
   wire sda_f     = lk_pins[0];
   wire bus_start = scl_f & scl_p_q & sda_p_q & ~sda_f;
   wire bus_stop  = scl_f & scl_p_q & ~sda_p_q & sda_f;
   wire scl_rise  = scl_f & ~scl_p_q;
   wire scl_fall  = ~scl_f & scl_p_q;
   wire ack_slot  = (bit_cnt_q == 4'd8);
   wire addr_hit  = (sh_q[7:1] == `BUS_ADDR);
   wire receiving = (lst_q == L_ADDR) | (lst_q == L_SUB) | (lst_q == L_WR);
   wire rd_bit    = rd_data_q[3'(7 - bit_cnt_q)];
   wire read_go   = scl_fall & ack_slot & (lst_q == L_ADDR) & addr_hit & sh_q[0];
   wire write_go  = scl_rise & ack_slot & (lst_q == L_WR);
   wire reread_go = scl_rise & ack_slot & (lst_q == L_RD) & ~sda_f;

   // Edge history of the filtered bus lines
   always_ff @(posedge LINK_CLK or negedge RST_N) begin
      if (!RST_N) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_f;
         sda_p_q <= sda_f;
      end
   end

   // Frame sequencer: address, sub-address, data bytes
   always_ff @(posedge LINK_CLK or negedge RST_N) begin
      if (!RST_N) begin
         lst_q     <= L_IDLE;
         bit_cnt_q <= 4'h0;
         sh_q      <= 8'h00;
         ptr_q     <= 2'h0;
         rd_dir_q  <= 1'b0;
      end else if (bus_stop) begin
         lst_q <= L_IDLE;
      end else if (bus_start) begin
         lst_q     <= L_ADDR;
         bit_cnt_q <= 4'h0;
      end else if (scl_rise && lst_q != L_IDLE) begin
         if (!ack_slot) begin
            sh_q      <= {sh_q[6:0], sda_f};
            bit_cnt_q <= bit_cnt_q + 4'h1;
         end else begin
            bit_cnt_q <= 4'h0;
            unique case (lst_q)
               L_IDLE: lst_q <= L_IDLE;
               L_ADDR: begin
                  rd_dir_q <= sh_q[0];
                  lst_q    <= !addr_hit ? L_IDLE : (sh_q[0] ? L_RD : L_SUB);
               end
               L_SUB:  begin
                  ptr_q <= sh_q[1:0];
                  lst_q <= L_WR;
               end
               L_WR:   ptr_q <= ptr_q + 2'h1;
               L_RD:   begin
                  ptr_q <= ptr_q + 2'h1;
                  lst_q <= sda_f ? L_IDLE : L_RD;
               end
            endcase
         end
      end
   end

   // Data line drive: ack after received bytes, data bits while reading
   // RULE2 open drain
   always_ff @(posedge LINK_CLK or negedge RST_N) begin
      if (!RST_N) begin
         sda_oe_q <= 1'b0;
      end else if (bus_stop || bus_start || lst_q == L_IDLE) begin
         sda_oe_q <= 1'b0;
      end else if (scl_fall) begin
         if (receiving && ack_slot)
            sda_oe_q <= (lst_q != L_ADDR) | addr_hit;
         else if (lst_q == L_RD && !ack_slot)
            sda_oe_q <= ~rd_bit;
         else
            sda_oe_q <= 1'b0;
      end
   end

   // Register requests toward the core, held steady until the next request
   always_ff @(posedge LINK_CLK or negedge RST_N) begin
      if (!RST_N) begin
         req_tgl_q <= 1'b0;
         req_q     <= '0;
      end else if (write_go) begin
         req_q     <= '{wr: 1'b1, idx: ptr_q, data: sh_q};
         req_tgl_q <= ~req_tgl_q;
      end else if (read_go) begin
         req_q     <= '{wr: 1'b0, idx: ptr_q, data: 8'h00};
         req_tgl_q <= ~req_tgl_q;
      end else if (reread_go) begin
         req_q     <= '{wr: 1'b0, idx: ptr_q + 2'h1, data: 8'h00};
         req_tgl_q <= ~req_tgl_q;
      end
   end

   assign SDA_O  = 1'b0;
   assign SDA_OE = sda_oe_q;

   // ---------------- Core domain ----------------
   logic [10:0] core_pins;
   logic        req_seen_q;
   logic [7:0]  level_q;
   logic [7:0]  timer_q;
   logic [7:0]  strobe_q;
   logic [3:0]  fault_q;
   logic        trig_p_q;
   logic        timed_q;
   logic [`TMR_W-1:0] flash_cnt_q;
   logic [`TMR_W-1:0] short_cnt_q;
   logic        int_oe_q;
   logic        drv_en_q;
   logic        flash_on_q;
   logic        torch_on_q;
   logic        ind_on_q;
   logic [4:0]  led_code_q;
   logic        req_s;

   // Pins and the request toggle into the core domain
   pin_sync #(.W(11)) u_core_sync (
      .clk   (CLOCK),
      .rst_n (RST_N),
      .d     ({req_tgl_q, INTERFACE_SELECT, MODE_PIN_HI, MODE_PIN_LO, FLASH_TRIGGER_PIN,
               ENABLE, UVLO, OVERVOLT, OVERHEAT, CATHODE_LOW, 1'b0}),
      .q     (core_pins)
   );

   assign req_s          = core_pins[10];
   wire   logic_mode     = core_pins[9];
   wire   hi_f           = core_pins[8];
   wire   lo_f           = core_pins[7];
   wire   trig_pin_f     = core_pins[6];
   wire   enable_f       = core_pins[5];
   wire   uvlo_f         = core_pins[4];
   wire   ov_f           = core_pins[3];
   wire   ot_f           = core_pins[2];
   wire   cath_low_f     = core_pins[1];

   // Flash window from the duration code
   // RULE17 window arithmetic
   function automatic logic [`TMR_W-1:0] flash_window(input logic [3:0] code);
      flash_window = `TMR_W'(WINDOW_CYCLES - 32'(code) * STEP_CYCLES);
   endfunction : flash_window

   // Register request decode
   wire       req_new   = (req_s != req_seen_q);
   wire       reg_wr    = req_new & req_q.wr & ~logic_mode;
   wire [7:0] fault_rd  = {4'h0, fault_q};
   wire [7:0] rd_mux    = (req_q.idx == `REG_LEVEL)  ? level_q  :
                          (req_q.idx == `REG_TIMER)  ? timer_q  :
                          (req_q.idx == `REG_STROBE) ? strobe_q : fault_rd;

   // RULE15 RULE16 wipe on enable low or undervoltage
   wire wipe = ~enable_f | uvlo_f;

   // Mode decode for both interface styles
   wire [4:0] led_code    = level_q[`LED_CODE_MSB:`LED_CODE_LSB];
   wire       timed_sel   = timer_q[`TIMED_SEL_BIT];
   wire [3:0] dur_code    = timer_q[`DUR_CODE_MSB:0];
   wire       ser_torch   = (led_code != 5'h00) & (led_code <= `TORCH_MAX_CODE);
   wire       ser_flash   = (led_code >= `FLASH_MIN_CODE);
   wire       trigger     = trig_pin_f | strobe_q[`SW_STROBE_BIT];
   wire       trig_rise   = trigger & ~trig_p_q;
   wire       fault_any   = |fault_q;
   wire [`TMR_W-1:0] window = flash_window(logic_mode ? 4'h0 : dur_code);

   // RULE14 requests follow pins and codes at any time
   wire torch_req = logic_mode ? (hi_f & ~lo_f) : ser_torch;
   // RULE18 user mode follows the strobe
   wire flash_req = logic_mode ? (hi_f & lo_f) :
                    (ser_flash & (timed_sel ? timed_q : trigger));
   wire ind_req   = logic_mode ? (~hi_f & lo_f) : (level_q[`IND_CODE_MSB:0] != 3'h0);

   // Timers and fault events
   wire flash_run    = flash_req & ~fault_any;
   wire window_done  = flash_run & (flash_cnt_q >= window);
   // RULE9 RULE10 watchdog timeout, not raised by timed mode
   wire tmo_event    = window_done & (logic_mode | ~timed_sel);
   // RULE12 cathode still grounded after the torch delay
   wire short_event  = torch_req & ~fault_any & (short_cnt_q == `TMR_W'(SHORT_CYCLES))
                       & cath_low_f;
   wire [3:0] set_vec;
   // RULE7 RULE11 RULE19 flag positions
   assign set_vec[`BIT_OVERVOLT] = ov_f;
   assign set_vec[`BIT_TIMEOUT]  = tmo_event;
   assign set_vec[`BIT_OVERHEAT] = ot_f;
   assign set_vec[`BIT_SHORT]    = short_event;

   // RULE4 serial clear by writing zero to level select
   wire ser_clear = reg_wr & (req_q.idx == `REG_LEVEL) & (req_q.data == `CLEAR_VALUE);
   // RULE6 two-pin clear with both mode pins low
   wire pin_clear = logic_mode & ~hi_f & ~lo_f;
   // RULE8 flags hold until cleared, a new event beats the clear
   wire [3:0] fault_d = wipe ? 4'h0 : (((ser_clear | pin_clear) ? 4'h0 : fault_q) | set_vec);

   // Request handshake with the link domain
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         req_seen_q <= 1'b0;
         rd_data_q  <= 8'h00;
      end else if (req_new) begin
         req_seen_q <= req_s;
         // RULE3 fault register readable over the link
         rd_data_q  <= rd_mux;
      end
   end

   // Writable registers
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         level_q  <= `REG_RESET;
         timer_q  <= `REG_RESET;
         strobe_q <= `REG_RESET;
      end else if (wipe) begin
         level_q  <= `REG_RESET;
         timer_q  <= `REG_RESET;
         strobe_q <= `REG_RESET;
      end else if (reg_wr) begin
         if (req_q.idx == `REG_LEVEL)  level_q  <= req_q.data;
         if (req_q.idx == `REG_TIMER)  timer_q  <= req_q.data;
         if (req_q.idx == `REG_STROBE) strobe_q <= req_q.data;
      end
   end

   // Fault flags
   // RULE1 RULE5 latched in both modes
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) fault_q <= 4'h0;
      else        fault_q <= fault_d;
   end

   // Timed-flash latch, started by a strobe edge and ended by the window
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         trig_p_q <= 1'b0;
         timed_q  <= 1'b0;
      end else begin
         trig_p_q <= trigger;
         if (wipe || fault_any || !timed_sel || window_done)
            timed_q <= 1'b0;
         else if (trig_rise && ser_flash)
            timed_q <= 1'b1;
      end
   end

   // Flash watchdog counter
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N)         flash_cnt_q <= '0;
      else if (!flash_run) flash_cnt_q <= '0;
      else if (!window_done) flash_cnt_q <= flash_cnt_q + `TMR_W'(1);
   end

   // Torch short-detect delay counter, saturating
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N)
         short_cnt_q <= '0;
      else if (!torch_req || fault_any)
         short_cnt_q <= '0;
      else if (short_cnt_q != `TMR_W'(SHORT_CYCLES))
         short_cnt_q <= short_cnt_q + `TMR_W'(1);
   end

   // Driver outputs, all but LED_CODE forced off while a fault stands
   // RULE8 stay disabled
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         drv_en_q   <= 1'b0;
         flash_on_q <= 1'b0;
         torch_on_q <= 1'b0;
         ind_on_q   <= 1'b0;
         led_code_q <= 5'h00;
      end else begin
         drv_en_q   <= ~fault_d[0] & ~|fault_d & ~wipe;
         flash_on_q <= flash_run & ~window_done & ~|set_vec & ~wipe;
         torch_on_q <= torch_req & ~fault_any & ~|set_vec & ~wipe;
         ind_on_q   <= ind_req & ~fault_any & ~wipe;
         led_code_q <= logic_mode ? 5'h00 : led_code;
      end
   end

   // Interrupt pin: pulled low while any flag stands
   // RULE1 RULE2 pull low only
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) int_oe_q <= 1'b0;
      else        int_oe_q <= |fault_d;
   end

   assign INT_O        = 1'b0;
   assign INT_OE       = int_oe_q;
   assign DRIVER_EN    = drv_en_q;
   assign FLASH_ON     = flash_on_q;
   assign TORCH_ON     = torch_on_q;
   assign INDICATOR_ON = ind_on_q;
   assign LED_CODE     = led_code_q;

endmodule : fault_monitor

/* File: fault_defs.svh */
// Offsets, field positions, reset values and timing counts of the fault monitor
// What the document requires
// RULE1 - Interrupt goes low on overvoltage, flash timeout or overtemperature.
// RULE2 - Interrupt pin is open-drain: only pulled low or released.
// RULE3 - Host reads the fault register after seeing the interrupt low.
// RULE4 - Serial mode: writing 0x00 to level select clears faults and interrupt.
// RULE5 - Two-pin mode raises the interrupt for the same faults, no readback.
// RULE6 - Two-pin mode: both mode pins low clears faults and interrupt.
// RULE7 - Overvoltage shuts down, asserts interrupt, sets fault bit 0.
// RULE8 - After any fault stay disabled with interrupt low until cleared.
// RULE9 - Two-pin mode: flash held over 820 ms raises interrupt and disables.
// RULE10 - Serial user mode: strobe high beyond window sets timeout flag, disables.
// RULE11 - Overtemperature shuts down driver, asserts interrupt, sets fault bit 2.
// RULE12 - Cathode still grounded 820 ms after torch enable sets bit 3, disables.
// RULE13 - Host passes through zero between torch levels 750 to 900 ms.
// RULE14 - Torch and flash may be enabled or disabled at any moment.
// RULE15 - Undervoltage loses registers; power-on restores defaults.
// RULE16 - All four registers reset to 0x00 on enable low or undervoltage.
// RULE17 - Flash window is 820 ms minus code times 54.6 ms.
// RULE18 - User timer mode keeps flash on only while strobe is high.
// RULE19 - Timeout flag sits at fault register bit 1.
`ifndef FAULT_DEFS_SVH
`define FAULT_DEFS_SVH

`define REG_LEVEL       2'h0
`define REG_TIMER       2'h1
`define REG_STROBE      2'h2
`define REG_FAULT       2'h3
`define REG_RESET       8'h00
`define CLEAR_VALUE     8'h00
`define BUS_ADDR        7'h30
`define BIT_OVERVOLT    0
`define BIT_TIMEOUT     1
`define BIT_OVERHEAT    2
`define BIT_SHORT       3
`define LED_CODE_MSB    7
`define LED_CODE_LSB    3
`define IND_CODE_MSB    2
`define TIMED_SEL_BIT   4
`define DUR_CODE_MSB    3
`define SW_STROBE_BIT   0
`define TORCH_MAX_CODE  5'h0b
`define FLASH_MIN_CODE  5'h0c
`define T_WINDOW_US     820000
`define T_STEP_US       54600
`define T_SHORT_US      820000
`define CLK_MHZ         25
`define TMR_W           25

`endif

/* File: fault_pkg.sv */
// Types shared by the fault monitor and its serial link logic
package fault_pkg;

   // Register request carried from the link domain to the core
   typedef struct packed {
      logic       wr;
      logic [1:0] idx;
      logic [7:0] data;
   } reg_req_t;

   // Serial link receiver states
   typedef enum logic [2:0] {
      L_IDLE,
      L_ADDR,
      L_SUB,
      L_WR,
      L_RD
   } link_state_t;

endpackage : fault_pkg

/* File: pin_sync.sv */
// Three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module pin_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   wire  [W-1:0] agree = ~(s2_q ^ s3_q);

   // Shift chain, output follows only agreeing bits
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         q    <= '0;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         q    <= (agree & s3_q) | (~agree & q);
      end
   end
endmodule : pin_sync

/* File: fault_check_monitor.sv */
// Concurrent checks on the fault monitor top-level pins
`timescale 1ns/10ps
module fault_check #(
   parameter int unsigned WINDOW_CYCLES = 300
) (
   input wire logic       CLOCK,
   input wire logic       RST_N,
   input wire logic       INTERFACE_SELECT,
   input wire logic       MODE_PIN_HI,
   input wire logic       MODE_PIN_LO,
   input wire logic       ENABLE,
   input wire logic       UVLO,
   input wire logic       OVERVOLT,
   input wire logic       OVERHEAT,
   input wire logic       INT_O,
   input wire logic       INT_OE,
   input wire logic       DRIVER_EN,
   input wire logic       FLASH_ON,
   input wire logic       TORCH_ON,
   input wire logic [4:0] LED_CODE
);
   logic [31:0] on_cnt_q;
   logic [31:0] on_cnt_d;

   // Length of the current flash
   assign on_cnt_d = FLASH_ON ? on_cnt_q + 32'h1 : 32'h0;
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) on_cnt_q <= 32'h0;
      else on_cnt_q <= on_cnt_d;
   end

   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_N);

   a_int_open_drain: assert property (INT_O == 1'b0)
      else $error("interrupt pin driven high");
   a_overvolt_int: assert property
      ((OVERVOLT && ENABLE && !UVLO)[*8] |-> INT_OE && !DRIVER_EN)
      else $error("overvoltage did not raise interrupt");
   a_overheat_int: assert property
      ((OVERHEAT && ENABLE && !UVLO)[*8] |-> INT_OE && !DRIVER_EN)
      else $error("overheat did not raise interrupt");
   a_fault_stops: assert property ($rose(INT_OE) |=> !DRIVER_EN && !FLASH_ON && !TORCH_ON)
      else $error("driver still active after fault");
   a_fault_holds: assert property
      ((INT_OE && INTERFACE_SELECT && MODE_PIN_HI && ENABLE && !UVLO)[*6] |=> INT_OE)
      else $error("interrupt released without a clear");
   a_logic_clear: assert property
      ((INTERFACE_SELECT && !MODE_PIN_HI && !MODE_PIN_LO && !OVERVOLT && !OVERHEAT)[*8]
       |-> !INT_OE)
      else $error("pin clear did not release interrupt");
   a_wipe_all: assert property
      ((!ENABLE || UVLO)[*8] |-> !INT_OE && !DRIVER_EN && LED_CODE == 5'h00)
      else $error("disable or undervoltage did not wipe state");
   a_logic_no_code: assert property (INTERFACE_SELECT[*8] |-> LED_CODE == 5'h00)
      else $error("level code shown in logic mode");
   a_flash_window: assert property (on_cnt_q <= WINDOW_CYCLES + 4)
      else $error("flash outlived its window");

   // Main scenarios reached
   c_int_seen: cover property ($rose(INT_OE));
   c_flash_end: cover property ($fell(FLASH_ON));
   c_torch_on: cover property ($rose(TORCH_ON));
endmodule : fault_check

bind fault_monitor fault_check #(.WINDOW_CYCLES(WINDOW_CYCLES)) u_check (
   .CLOCK(CLOCK), .RST_N(RST_N), .INTERFACE_SELECT(INTERFACE_SELECT),
   .MODE_PIN_HI(MODE_PIN_HI), .MODE_PIN_LO(MODE_PIN_LO), .ENABLE(ENABLE), .UVLO(UVLO),
   .OVERVOLT(OVERVOLT), .OVERHEAT(OVERHEAT), .INT_O(INT_O), .INT_OE(INT_OE),
   .DRIVER_EN(DRIVER_EN), .FLASH_ON(FLASH_ON), .TORCH_ON(TORCH_ON), .LED_CODE(LED_CODE)
);

/* File: fault_host.sv */
// Serial bus host model that reaches the fault monitor registers
`timescale 1ns/10ps
module fault_host (
   input  wire logic sda,
   output logic      scl,
   output logic      sda_low
);
   localparam time PH = 1000ns;

   // Bus idle: clock high, data released to the pull-up
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // Start or repeated start, leaves the clock low
   task automatic start();
      sda_low = 1'b0;
      #PH scl = 1'b1;
      #PH sda_low = 1'b1;
      #PH scl = 1'b0;
   endtask : start

   // Stop, leaves the bus idle
   task automatic stop();
      sda_low = 1'b1;
      #PH scl = 1'b1;
      #PH sda_low = 1'b0;
      #PH;
   endtask : stop

   // One bit: data set while clock low, sampled at end of high phase
   task automatic bit_io(input logic b, output logic r);
      sda_low = !b;
      #PH scl = 1'b1;
      #PH r = sda;
      scl = 1'b0;
   endtask : bit_io

   // Eight bits out and in, then a released ninth bit
   task automatic byte_io(input logic [7:0] d, output logic [7:0] r, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
      bit_io(1'b1, a);
      ack = !a;
   endtask : byte_io

   // Register write frame
   task automatic wr(input logic [1:0] idx, input logic [7:0] d, output logic ok);
      logic [7:0] r;
      logic       a0, a1, a2;
      start();
      byte_io(8'h60, r, a0);
      byte_io({6'h00, idx}, r, a1);
      byte_io(d, r, a2);
      stop();
      ok = a0 & a1 & a2;
   endtask : wr

   task automatic rd(input logic [1:0] idx, output logic [7:0] d, output logic ok);
      logic [7:0] r;
      logic       a0, a1, a2, a3;
      start();
      byte_io(8'h60, r, a0);
      byte_io({6'h00, idx}, r, a1);
      start();
      byte_io(8'h61, r, a2);
      byte_io(8'hff, d, a3);
      stop();
      ok = a0 & a1 & a2;
   endtask : rd
endmodule : fault_host

/* File: fault_monitor_tb.sv */
// Self-checking bench for the fault monitor
`timescale 1ns/10ps
module fault_monitor_tb;
   localparam int unsigned WIN   = 300;
   localparam int unsigned STEP  = 18;
   localparam int unsigned SHORT = 200;
   logic       CLOCK, RST_N, LINK_CLK, SCL, host_low, SDA_O, SDA_OE, sda;
   logic       sel, mhi, mlo, trig, ENABLE, UVLO, OVERVOLT, OVERHEAT, CATHODE_LOW;
   logic       INT_O, INT_OE, DRIVER_EN, FLASH_ON, TORCH_ON, INDICATOR_ON;
   logic [4:0] LED_CODE;
   int         n_mismatch = 0;
   int         total_checks = 0;

   // Open-drain data line with pull-up
   assign sda = !(host_low || SDA_OE);

   fault_monitor #(.WINDOW_CYCLES(WIN), .STEP_CYCLES(STEP), .SHORT_CYCLES(SHORT)) dut (
      .CLOCK(CLOCK), .RST_N(RST_N), .LINK_CLK(LINK_CLK), .SCL(SCL), .SDA_I(sda),
      .SDA_O(SDA_O), .SDA_OE(SDA_OE), .INTERFACE_SELECT(sel), .MODE_PIN_HI(mhi),
      .MODE_PIN_LO(mlo), .FLASH_TRIGGER_PIN(trig), .ENABLE(ENABLE), .UVLO(UVLO),
      .OVERVOLT(OVERVOLT), .OVERHEAT(OVERHEAT), .CATHODE_LOW(CATHODE_LOW), .INT_O(INT_O),
      .INT_OE(INT_OE), .DRIVER_EN(DRIVER_EN), .FLASH_ON(FLASH_ON), .TORCH_ON(TORCH_ON),
      .INDICATOR_ON(INDICATOR_ON), .LED_CODE(LED_CODE));
   fault_host host (.sda(sda), .scl(SCL), .sda_low(host_low));

   // Core and link clocks, unrelated in phase
   initial begin
      CLOCK = 1'b0;
      forever #20 CLOCK = ~CLOCK;
   end
   initial begin
      LINK_CLK = 1'b0;
      #7;
      forever #15 LINK_CLK = ~LINK_CLK;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic close_out();
      if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : close_out

   // Bus helpers with settle time for the register update
   task automatic wreg(input logic [1:0] idx, input logic [7:0] d);
      logic ok;
      host.wr(idx, d, ok);
      chk(8'(ok), 8'h01);
      repeat (8) @(posedge CLOCK);
   endtask : wreg
   task automatic rreg(input logic [1:0] idx, input logic [7:0] exp);
      logic [7:0] v;
      logic       ok;
      host.rd(idx, v, ok);
      chk(v, exp);
      @(posedge CLOCK);
   endtask : rreg

   // Bounded waits, sampled on the falling edge
   task automatic wait_int(input logic lvl);
      for (int i = 0; i < 2000 && INT_OE !== lvl; i++) @(negedge CLOCK);
      chk(8'(INT_OE), 8'(lvl));
      @(posedge CLOCK);
   endtask : wait_int
   task automatic measure_flash(output int n);
      n = 0;
      for (int i = 0; i < 2000 && FLASH_ON !== 1'b1; i++) @(negedge CLOCK);
      while (FLASH_ON === 1'b1 && n < 2000) begin
         n++;
         @(negedge CLOCK);
      end
      @(posedge CLOCK);
   endtask : measure_flash

   task automatic t_regs();
      for (int i = 0; i < 4; i++) rreg(i[1:0], 8'h00);
      wreg(2'h1, 8'h1f);
      rreg(2'h1, 8'h1f);
      wreg(2'h3, 8'h0f);
      rreg(2'h3, 8'h00);
      chk(8'({INT_O, SDA_O}), 8'h00);
   endtask : t_regs

   task automatic t_wipe();
      for (int k = 0; k < 2; k++) begin
         wreg(2'h0, 8'h5b);
         rreg(2'h0, 8'h5b);
         chk(8'({DRIVER_EN, TORCH_ON, INDICATOR_ON, LED_CODE}), 8'heb);
         if (k == 0) ENABLE <= 1'b0;
         else UVLO <= 1'b1;
         repeat (12) @(posedge CLOCK);
         chk(8'({DRIVER_EN, TORCH_ON, INDICATOR_ON}), 8'h00);
         ENABLE <= 1'b1;
         UVLO <= 1'b0;
         repeat (10) @(posedge CLOCK);
         rreg(2'h0, 8'h00);
      end
   endtask : t_wipe

   task automatic t_comp();
      for (int k = 0; k < 2; k++) begin
         if (k == 0) OVERVOLT <= 1'b1;
         else OVERHEAT <= 1'b1;
         wait_int(1'b1);
         repeat (8) @(posedge CLOCK);
         OVERVOLT <= 1'b0;
         OVERHEAT <= 1'b0;
         repeat (20) @(posedge CLOCK);
         chk(8'({INT_OE, DRIVER_EN}), 8'h02);
         rreg(2'h3, k ? 8'h04 : 8'h01);
         wreg(2'h0, 8'h00);
         wait_int(1'b0);
         rreg(2'h3, 8'h00);
      end
   endtask : t_comp

   task automatic t_timeout();
      int n;
      wreg(2'h1, 8'h10);
      wreg(2'h0, 8'h60);
      wreg(2'h2, 8'h01);
      chk(8'(FLASH_ON), 8'h01);
      repeat (220) @(posedge CLOCK);
      chk(8'({INT_OE, FLASH_ON}), 8'h00);
      wreg(2'h2, 8'h00);
      wreg(2'h1, 8'h02);
      wreg(2'h0, 8'h60);
      trig <= 1'b1;
      repeat (40) @(posedge CLOCK);
      chk(8'(FLASH_ON), 8'h01);
      trig <= 1'b0;
      repeat (10) @(posedge CLOCK);
      chk(8'({INT_OE, FLASH_ON}), 8'h00);
      trig <= 1'b1;
      measure_flash(n);
      chk(8'(n + 4 >= WIN - 2 * STEP && n <= WIN - 2 * STEP + 4), 8'h01);
      wait_int(1'b1);
      rreg(2'h3, 8'h02);
      trig <= 1'b0;
      wreg(2'h0, 8'h00);
      wait_int(1'b0);
   endtask : t_timeout

   task automatic t_short();
      CATHODE_LOW <= 1'b1;
      wreg(2'h0, 8'h08);
      chk(8'({TORCH_ON, INT_OE}), 8'h02);
      wait_int(1'b1);
      rreg(2'h3, 8'h08);
      CATHODE_LOW <= 1'b0;
      wreg(2'h0, 8'h00);
      wait_int(1'b0);
   endtask : t_short

   task automatic t_logic();
      int n;
      sel <= 1'b1;
      repeat (10) @(posedge CLOCK);
      chk(8'(LED_CODE), 8'h00);
      {mhi, mlo} <= 2'b11;
      measure_flash(n);
      chk(8'(n + 4 >= WIN && n <= WIN + 4), 8'h01);
      wait_int(1'b1);
      repeat (10) @(posedge CLOCK);
      chk(8'({INT_OE, FLASH_ON}), 8'h02);
      {mhi, mlo} <= 2'b00;
      wait_int(1'b0);
      {mhi, mlo} <= 2'b10;
      repeat (10) @(posedge CLOCK);
      chk(8'(TORCH_ON), 8'h01);
      OVERHEAT <= 1'b1;
      wait_int(1'b1);
      repeat (8) @(posedge CLOCK);
      OVERHEAT <= 1'b0;
      repeat (20) @(posedge CLOCK);
      chk(8'(INT_OE), 8'h01);
      {mhi, mlo} <= 2'b00;
      wait_int(1'b0);
      sel <= 1'b0;
   endtask : t_logic

   // Main sequence
   initial begin
      RST_N = 1'b0;
      ENABLE = 1'b1;
      UVLO = 1'b0;
      sel = 1'b0;
      mhi = 1'b0;
      mlo = 1'b0;
      trig = 1'b0;
      OVERVOLT = 1'b0;
      OVERHEAT = 1'b0;
      CATHODE_LOW = 1'b0;
      repeat (5) @(posedge CLOCK);
      RST_N <= 1'b1;
      repeat (10) @(posedge CLOCK);
      t_regs();
      t_wipe();
      t_comp();
      t_timeout();
      t_short();
      t_logic();
      close_out();
   end

   // Watchdog against a hang
   initial begin
      #3ms;
      n_mismatch++;
      close_out();
   end
endmodule : fault_monitor_tb
